// File: rtl/tpe_defs.svh
// Constants for the terminal panel and error logic
`ifndef TPE_DEFS_SVH
`define TPE_DEFS_SVH

`define TPE_CLK_HZ          100000000
`define TPE_ALARM_MS        250
`define TPE_ALARM_CYCLES    (`TPE_ALARM_MS * (`TPE_CLK_HZ / 1000))
`define TPE_LAST_COLUMN     8'd132
`define TPE_CHAR_CR         8'h0d
`define TPE_CHAR_ETX        8'h03
`define TPE_CHAR_EOT        8'h04
`define TPE_CHAR_BEL        8'h07
`define TPE_CHAR_NAK        8'h15
`define TPE_CHAR_NOT        8'hac
`define TPE_KBD_CHECK_A     8'h76
`define TPE_KBD_CHECK_B     8'h09
`define TPE_NUM_ERRORS      7
`define TPE_ERR_PARITY      0
`define TPE_ERR_PRINTER     1
`define TPE_ERR_OVFL        2
`define TPE_ERR_COVER       3
`define TPE_ERR_PAPER       4
`define TPE_ERR_ATTN        5
`define TPE_ERR_RIBBON      6

`endif

// File: rtl/tpe_flag.sv
// Sticky error flag with operator clear
`default_nettype none
module tpe_flag (
    input  wire logic clk_sys_i,
    input  wire logic reset_i,
    input  wire logic set_i,
    input  wire logic cond_i,
    input  wire logic clr_i,
    output logic      flag_o
);
    logic flag_q;
    logic flag_d;

    // Set beats clear; clear only once the cause has gone
    always_comb begin
        flag_d = flag_q;
        if (clr_i && !cond_i) begin
            flag_d = 1'b0;
        end
        if (set_i) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag_o = flag_q;

    flag_sticky_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        flag_q && !(clr_i && !cond_i) |=> flag_q)
        else $error("flag dropped without clear");
    flag_set_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        set_i |=> flag_q)
        else $error("flag not set by its event");
endmodule
`default_nettype wire

// File: rtl/tpe_pkg.sv
// Types for the terminal panel and error logic
`default_nettype none
package tpe_pkg;
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_ROM  = 8'h02,
        ST_RAM  = 8'h04,
        ST_KBD  = 8'h08,
        ST_KC1  = 8'h10,
        ST_KC2  = 8'h20,
        ST_PRN  = 8'h40,
        ST_HALT = 8'h80
    } tpe_state_type;

    typedef enum logic [1:0] {
        PK_OK   = 2'h0,
        PK_BAD  = 2'h1,
        PK_CODE = 2'h2
    } tpe_print_kind_type;
endpackage
`default_nettype wire

// File: rtl/tpe_top.sv
// Panel switch, self-test and error lamp logic of the terminal
//
// Contract
// - Reverse channel needs switch and line mode
// - Auto return past column 132 does CR/LF
// - Auto_return_enable/LF is local, never on link
// - Line mode sampled at power-up only
// - Turn-around char is ETX or EOT
// - Turn-around sent after each transmitted CR; code sends it only in line mode with turnaround_after_return_i on
// - Self-test switch at power-up runs checks
// - Error-free self-test repeats while switch on
// - Self-test error halts cycle, all lamps
// - ROM/RAM checks print OK or BAD
// - Keyboard check prints keys, 76, 09
// - DIP switch 1 selects pattern A/B
// - Pattern A prints full font line
// - Pattern B prints both directions, tabs
// - Errors sound quarter-second alarm, light lamp
// - Alarm on BEL and margin, not 132
// - Parity lamp; bad characters become NOT
// - Printer-check and overflow lamps
// - Cover and paper lamps on print attempt
// - Attention on break, NAK in line mode
// - Ribbon lamp on no ribbon motion
// - Lamps latch until gone and reset key
// - Line mode forces half duplex
// - Framing check only with parity enabled
`include "tpe_defs.svh"
`default_nettype none
module tpe_top #(
    parameter int unsigned ALARM_CYCLES = `TPE_ALARM_CYCLES
) (
    input  wire logic                    clk_sys_i,
    input  wire logic                    reset_i,
    input  wire logic                    line_switch_i,
    input  wire logic                    test_switch_i,
    input  wire logic                    reverse_channel_enable_i,
    input  wire logic                    auto_return_enable_i,
    input  wire logic                    turnaround_char_select_i,
    input  wire logic                    turnaround_after_return_i,
    input  wire logic                    duplex_switch_i,
    input  wire logic                    parity_enable_i,
    input  wire logic                    paper_out_defeat_i,
    input  wire logic                    printer_test_select_i,
    input  wire logic                    reset_key_i,
    input  wire logic [7:0]              tx_char_i,
    input  wire logic                    tx_valid_i,
    output logic                         tx_ready_o,
    output logic [7:0]                   link_tx_data_o,
    output logic                         link_tx_valid_o,
    input  wire logic                    link_tx_ready_i,
    input  wire logic [7:0]              rx_char_i,
    input  wire logic                    rx_valid_i,
    input  wire logic                    rx_parity_err_i,
    input  wire logic                    rx_framing_err_i,
    input  wire logic                    rx_overrun_i,
    input  wire logic                    break_rx_i,
    output logic [7:0]                   rx_char_o,
    output logic                         rx_valid_o,
    input  wire logic                    rev_break_req_i,
    input  wire logic                    sec_rx_data_i,
    output logic                         sec_tx_data_o,
    output logic                         rev_break_rx_o,
    input  wire logic                    move_attempt_i,
    input  wire logic [7:0]              next_column_i,
    input  wire logic [7:0]              right_margin_i,
    output logic                         local_cr_o,
    output logic                         local_lf_o,
    input  wire logic                    print_attempt_i,
    input  wire logic                    printer_check_i,
    input  wire logic                    cover_open_i,
    input  wire logic                    paper_out_i,
    input  wire logic                    buffer_ovfl_i,
    input  wire logic                    ribbon_stalled_i,
    input  wire logic                    check_done_i,
    input  wire logic                    check_fail_i,
    input  wire logic [7:0]              kbd_key_code_i,
    input  wire logic                    kbd_key_valid_i,
    output tpe_pkg::tpe_state_type       test_state_o,
    output logic                         check_start_o,
    output logic                         pattern_b_o,
    output logic                         test_print_valid_o,
    output tpe_pkg::tpe_print_kind_type  test_print_kind_o,
    output logic [7:0]                   test_print_code_o,
    output logic                         line_mode_o,
    output logic                         half_duplex_o,
    output logic                         reverse_channel_active_o,
    output logic [`TPE_NUM_ERRORS-1:0]   error_lamps_o,
    output logic                         alarm_o,
    output logic                         printer_enable_o,
    output logic                         printer_restore_o
);
    import tpe_pkg::*;

    localparam int unsigned AW = $clog2(ALARM_CYCLES + 1);

    // ----------------------------------------------------------------
    // Power-up straps
    // ----------------------------------------------------------------
    logic started_q, started_d;
    logic line_mode_q, line_mode_d;
    logic test_req_q, test_req_d;

    // Caught on the first edge after release, then frozen
    always_comb begin
        started_d   = 1'b1;
        line_mode_d = line_mode_q;
        test_req_d  = 1'b0;
        if (!started_q) begin
            line_mode_d = line_switch_i;
            test_req_d  = test_switch_i;
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            started_q   <= 1'b0;
            line_mode_q <= 1'b0;
            test_req_q  <= 1'b0;
        end else begin
            started_q   <= started_d;
            line_mode_q <= line_mode_d;
            test_req_q  <= test_req_d;
        end
    end

    assign line_mode_o   = line_mode_q;
    assign half_duplex_o = line_mode_q || !duplex_switch_i;

    line_frozen_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        started_q |=> $stable(line_mode_q))
        else $error("line mode changed after power-up");

    // ----------------------------------------------------------------
    // Transmit path with turn-around insertion
    // ----------------------------------------------------------------
    logic       out_v_q, out_v_d;
    logic [7:0] out_c_q, out_c_d;
    logic       ta_pend_q, ta_pend_d;
    logic [7:0] ta_char;

    assign ta_char = turnaround_char_select_i ? `TPE_CHAR_EOT
                                              : `TPE_CHAR_ETX;
    assign tx_ready_o = !ta_pend_q && (!out_v_q || link_tx_ready_i);

    // Only the user stream and inserted turn-around chars reach the link; local CR/LF never enters
    always_comb begin
        out_v_d   = out_v_q;
        out_c_d   = out_c_q;
        ta_pend_d = ta_pend_q;
        if (out_v_q && link_tx_ready_i) begin
            out_v_d = 1'b0;
        end
        if (ta_pend_q && (!out_v_q || link_tx_ready_i)) begin
            out_v_d   = 1'b1;
            out_c_d   = ta_char;
            ta_pend_d = 1'b0;
        end else if (tx_valid_i && tx_ready_o) begin
            out_v_d   = 1'b1;
            out_c_d   = tx_char_i;
            ta_pend_d = line_mode_q && turnaround_after_return_i
                        && (tx_char_i == `TPE_CHAR_CR);
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            out_v_q   <= 1'b0;
            out_c_q   <= 8'h00;
            ta_pend_q <= 1'b0;
        end else begin
            out_v_q   <= out_v_d;
            out_c_q   <= out_c_d;
            ta_pend_q <= ta_pend_d;
        end
    end

    assign link_tx_valid_o = out_v_q;
    assign link_tx_data_o  = out_c_q;

    ta_after_cr_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        tx_valid_i && tx_ready_o && tx_char_i == `TPE_CHAR_CR && line_mode_q
        && turnaround_after_return_i ##1 link_tx_ready_i
        |=> link_tx_valid_o && (link_tx_data_o == $past(ta_char)))
        else $error("turn-around missing after CR");

    // ----------------------------------------------------------------
    // Receive path, reverse channel, column watch
    // ----------------------------------------------------------------
    logic       bad_char;
    logic       par_evt, attn_evt, bel_evt, margin_evt, over_evt;
    logic       rx_v_q, rx_v_d, rev_rx_q, rev_rx_d, sec_tx_q, sec_tx_d;
    logic       cr_q, cr_d;
    logic [7:0] rx_c_q, rx_c_d;

    assign bad_char = rx_parity_err_i && parity_enable_i
                      || rx_framing_err_i && parity_enable_i;
    assign par_evt  = rx_valid_i && (bad_char || rx_overrun_i);
    assign attn_evt = break_rx_i || rx_valid_i && line_mode_q
                      && rx_char_i == `TPE_CHAR_NAK;
    assign bel_evt  = rx_valid_i && rx_char_i == `TPE_CHAR_BEL;
    assign over_evt = move_attempt_i && next_column_i > `TPE_LAST_COLUMN;
    assign margin_evt = move_attempt_i && next_column_i > right_margin_i
                        && right_margin_i != `TPE_LAST_COLUMN;
    assign reverse_channel_active_o = reverse_channel_enable_i
                                      && line_mode_q;

    always_comb begin
        rx_v_d   = rx_valid_i;
        rx_c_d   = bad_char ? `TPE_CHAR_NOT : rx_char_i;
        sec_tx_d = !(reverse_channel_active_o && rev_break_req_i);
        rev_rx_d = reverse_channel_active_o && !sec_rx_data_i;
        cr_d     = auto_return_enable_i && over_evt;
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            rx_v_q   <= 1'b0;
            rx_c_q   <= 8'h00;
            sec_tx_q <= 1'b1;
            rev_rx_q <= 1'b0;
            cr_q     <= 1'b0;
        end else begin
            rx_v_q   <= rx_v_d;
            rx_c_q   <= rx_c_d;
            sec_tx_q <= sec_tx_d;
            rev_rx_q <= rev_rx_d;
            cr_q     <= cr_d;
        end
    end

    assign rx_valid_o     = rx_v_q;
    assign rx_char_o      = rx_c_q;
    assign sec_tx_data_o  = sec_tx_q;
    assign rev_break_rx_o = rev_rx_q;
    assign local_cr_o     = cr_q;
    assign local_lf_o     = cr_q;

    not_subst_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        rx_valid_i && parity_enable_i && rx_framing_err_i
        |=> rx_valid_o && rx_char_o == `TPE_CHAR_NOT)
        else $error("bad character not replaced");
    rev_gate_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !line_mode_q |=> sec_tx_data_o)
        else $error("reverse break outside line mode");
    auto_ret_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        auto_return_enable_i && move_attempt_i && next_column_i == 8'd133
        |=> local_cr_o && local_lf_o)
        else $error("no automatic return past last column");

    // ----------------------------------------------------------------
    // Error flags, operator reset, printer enable
    // ----------------------------------------------------------------
    logic [`TPE_NUM_ERRORS-1:0] err_set, err_cond, flags;
    logic key_q, key_d, rst_pulse;
    logic prn_en_q, prn_en_d, all_q, all_d;
    logic halt_entry;

    assign rst_pulse = reset_key_i && !key_q;

    always_comb begin
        err_set  = '0;
        err_cond = '0;
        err_set[`TPE_ERR_PARITY]   = par_evt;
        err_set[`TPE_ERR_PRINTER]  = print_attempt_i && printer_check_i;
        err_set[`TPE_ERR_OVFL]     = buffer_ovfl_i;
        err_set[`TPE_ERR_COVER]    = print_attempt_i && cover_open_i;
        err_set[`TPE_ERR_PAPER]    = print_attempt_i && paper_out_i
                                     && !paper_out_defeat_i;
        err_set[`TPE_ERR_ATTN]     = attn_evt;
        err_set[`TPE_ERR_RIBBON]   = ribbon_stalled_i;
        err_cond[`TPE_ERR_PRINTER] = printer_check_i;
        err_cond[`TPE_ERR_OVFL]    = buffer_ovfl_i;
        err_cond[`TPE_ERR_COVER]   = cover_open_i;
        err_cond[`TPE_ERR_PAPER]   = paper_out_i && !paper_out_defeat_i;
        err_cond[`TPE_ERR_ATTN]    = break_rx_i;
        err_cond[`TPE_ERR_RIBBON]  = ribbon_stalled_i;
    end

    for (genvar g = 0; g < `TPE_NUM_ERRORS; g++) begin : g_flag
        tpe_flag u_flag (
            .clk_sys_i (clk_sys_i),
            .reset_i   (reset_i),
            .set_i     (err_set[g]),
            .cond_i    (err_cond[g]),
            .clr_i     (rst_pulse),
            .flag_o    (flags[g])
        );
    end

    // Printer held off after a print fault until the operator resets
    always_comb begin
        key_d    = reset_key_i;
        prn_en_d = prn_en_q;
        all_d    = all_q;
        if (rst_pulse) begin
            prn_en_d = 1'b1;
            all_d    = 1'b0;
        end
        if (|err_set[`TPE_ERR_PAPER:`TPE_ERR_COVER]
            || err_set[`TPE_ERR_PRINTER]) begin
            prn_en_d = 1'b0;
        end
        if (halt_entry) begin
            all_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            key_q    <= 1'b0;
            prn_en_q <= 1'b1;
            all_q    <= 1'b0;
        end else begin
            key_q    <= key_d;
            prn_en_q <= prn_en_d;
            all_q    <= all_d;
        end
    end

    assign error_lamps_o     = flags | {`TPE_NUM_ERRORS{all_q}};
    assign printer_enable_o  = prn_en_q;
    assign printer_restore_o = rst_pulse;

    cover_lamp_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        print_attempt_i && cover_open_i
        |=> error_lamps_o[`TPE_ERR_COVER] && !printer_enable_o)
        else $error("cover lamp not lit");

    // ----------------------------------------------------------------
    // Alarm timer
    // ----------------------------------------------------------------
    logic [AW-1:0] alarm_q, alarm_d;

    // Retrigger restarts the full quarter second
    always_comb begin
        alarm_d = alarm_q;
        if (alarm_q != '0) begin
            alarm_d = alarm_q - AW'(1);
        end
        if (|err_set || bel_evt || margin_evt) begin
            alarm_d = AW'(ALARM_CYCLES);
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            alarm_q <= '0;
        end else begin
            alarm_q <= alarm_d;
        end
    end

    assign alarm_o = alarm_q != '0;

    alarm_start_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        buffer_ovfl_i |=> alarm_o && alarm_q == AW'(ALARM_CYCLES))
        else $error("alarm not started on error");
    margin_quiet_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !alarm_o && right_margin_i == `TPE_LAST_COLUMN && !(|err_set)
        && !bel_evt |=> !alarm_o)
        else $error("alarm at far right margin");

    // ----------------------------------------------------------------
    // Self-test sequencer
    // ----------------------------------------------------------------
    tpe_state_type      st_q, st_d;
    tpe_print_kind_type pk_q, pk_d;
    logic [7:0]         pc_q, pc_d;
    logic               pv_q, pv_d, fail_q, fail_d, start_q, start_d;

    assign halt_entry = st_q == ST_PRN && check_done_i
                        && (fail_q || check_fail_i);

    always_comb begin
        st_d    = st_q;
        pk_d    = PK_CODE;
        pc_d    = pc_q;
        pv_d    = 1'b0;
        fail_d  = fail_q;
        start_d = 1'b0;
        case (st_q)
            ST_IDLE: begin
                if (test_req_q) begin
                    st_d    = ST_ROM;
                    start_d = 1'b1;
                end
            end
            ST_ROM, ST_RAM: begin
                if (check_done_i) begin
                    pv_d    = 1'b1;
                    pk_d    = check_fail_i ? PK_BAD : PK_OK;
                    fail_d  = fail_q || check_fail_i;
                    st_d    = (st_q == ST_ROM) ? ST_RAM : ST_KBD;
                    start_d = 1'b1;
                end
            end
            ST_KBD: begin
                if (kbd_key_valid_i) begin
                    pv_d = 1'b1;
                    pc_d = kbd_key_code_i;
                end else if (check_done_i) begin
                    st_d = ST_KC1;
                end
            end
            ST_KC1: begin
                pv_d = 1'b1;
                pc_d = `TPE_KBD_CHECK_A;
                st_d = ST_KC2;
            end
            ST_KC2: begin
                pv_d    = 1'b1;
                pc_d    = `TPE_KBD_CHECK_B;
                st_d    = ST_PRN;
                start_d = 1'b1;
            end
            ST_PRN: begin
                if (halt_entry) begin
                    st_d = ST_HALT;
                end else if (check_done_i) begin
                    fail_d  = 1'b0;
                    st_d    = test_switch_i ? ST_ROM : ST_IDLE;
                    start_d = test_switch_i;
                end
            end
            ST_HALT: st_d = ST_HALT;
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            st_q    <= ST_IDLE;
            pk_q    <= PK_OK;
            pc_q    <= 8'h00;
            pv_q    <= 1'b0;
            fail_q  <= 1'b0;
            start_q <= 1'b0;
        end else begin
            st_q    <= st_d;
            pk_q    <= pk_d;
            pc_q    <= pc_d;
            pv_q    <= pv_d;
            fail_q  <= fail_d;
            start_q <= start_d;
        end
    end

    assign test_state_o       = st_q;
    assign check_start_o      = start_q;
    assign pattern_b_o        = printer_test_select_i;
    assign test_print_valid_o = pv_q;
    assign test_print_kind_o  = pk_q;
    assign test_print_code_o  = pc_q;

    halt_lamps_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        halt_entry |=> st_q == ST_HALT && error_lamps_o == '1)
        else $error("self-test error did not halt");
    kbd_codes_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        st_q == ST_KC1 |=> test_print_code_o == `TPE_KBD_CHECK_A
        ##1 test_print_code_o == `TPE_KBD_CHECK_B && test_print_valid_o)
        else $error("keyboard check codes missing");
    bad_word_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        st_q == ST_ROM && check_done_i && check_fail_i
        |=> test_print_valid_o && test_print_kind_o == PK_BAD)
        else $error("BAD not printed on failure");
endmodule
`default_nettype wire

// File: verification/terminal_panel_error_logic_tb.sv
// Self-checking bench for the panel and error logic
`include "tpe_defs.svh"
`default_nettype none
module terminal_panel_error_logic_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tpe_pkg::*;
    // ----
    // Signals
    // ----
    logic clk_sys_i = '0, reset_i = '1, line_switch_i = '1;
    logic test_switch_i = '0, reverse_channel_enable_i = '1;
    logic auto_return_enable_i = '1, turnaround_char_select_i = '0;
    logic turnaround_after_return_i = '1, duplex_switch_i = '1;
    logic parity_enable_i = '0, paper_out_defeat_i = '0;
    logic printer_test_select_i = '0, reset_key_i = '0, tx_valid_i = '0;
    logic rx_valid_i = '0, rx_parity_err_i = '0, rx_framing_err_i = '0;
    logic rx_overrun_i = '0, rev_break_req_i = '0, move_attempt_i = '0;
    logic print_attempt_i = '0, check_done_i = '0, check_fail_i = '0;
    logic kbd_key_valid_i = '0, link_tx_ready_i, sec_rx_data_i;
    logic buffer_ovfl_i, break_rx_i, ribbon_stalled_i, printer_check_i;
    logic cover_open_i, paper_out_i;
    logic [5:0] cond = '0;
    logic [7:0] tx_char_i = '0, rx_char_i = '0, next_column_i = '0;
    logic [7:0] right_margin_i = 8'h84, kbd_key_code_i = '0;
    logic tx_ready_o, link_tx_valid_o, rx_valid_o, sec_tx_data_o;
    logic rev_break_rx_o, local_cr_o, local_lf_o, check_start_o;
    logic pattern_b_o, test_print_valid_o, line_mode_o, half_duplex_o;
    logic reverse_channel_active_o, alarm_o, printer_enable_o;
    logic printer_restore_o;
    logic [7:0] link_tx_data_o, rx_char_o, test_print_code_o;
    logic [6:0] error_lamps_o;
    tpe_state_type test_state_o;
    tpe_print_kind_type test_print_kind_o;
    int num_errors = 0, compares = 0;
    logic [7:0] qtx[$], qrx[$];
    assign {buffer_ovfl_i, break_rx_i, ribbon_stalled_i, printer_check_i,
            cover_open_i, paper_out_i} = cond;
    // Short alarm keeps the run brief
    tpe_top #(.ALARM_CYCLES(20)) tpe_top_inst (.*);
    tpe_link_model tpe_link_model_inst (
        .clk_sys_i       (clk_sys_i),
        .link_tx_valid_i (link_tx_valid_o),
        .link_tx_ready_o (link_tx_ready_i),
        .sec_rx_data_o   (sec_rx_data_i)
    );
    always #5 clk_sys_i = ~clk_sys_i;
    // ----
    // Tasks
    // ----
    task automatic chk(string n, logic [7:0] e, logic [7:0] s);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    task automatic key();
        reset_key_i = 1'b1;
        cyc(2);
        reset_key_i = 1'b0;
        cyc(2);
    endtask
    // Leaves valid high so bytes can follow back to back
    task automatic send(logic [7:0] c);
        tx_char_i = c;
        tx_valid_i = 1'b1;
        while (tx_ready_o !== 1'b1) @(negedge clk_sys_i);
        cyc(1);
    endtask
    task automatic rx(logic [7:0] c, logic fe, logic [7:0] e);
        rx_char_i = c;
        rx_framing_err_i = fe;
        rx_valid_i = 1'b1;
        qrx.push_back(e);
        cyc(1);
        rx_valid_i = 1'b0;
    endtask
    task automatic finish_test();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Any byte or character not noted beforehand is a mismatch
    always @(posedge clk_sys_i) begin
        if (link_tx_valid_o === 1'b1 && link_tx_ready_i === 1'b1)
            chk("link", qtx.size() ? qtx.pop_front() : 8'hxx,
                link_tx_data_o);
        if (rx_valid_o === 1'b1)
            chk("rx", qrx.size() ? qrx.pop_front() : 8'hxx,
                rx_char_o);
    end
    // ----
    // Tests
    // ----
    initial begin
        logic [7:0] r;
        int bits[6] = '{4, 3, 1, 6, 5, 2};
        void'($urandom(32'h0d403f07));
        cyc(10);
        reset_i = 1'b0;
        cyc(3);
        line_switch_i = 1'b0;
        cyc(2);
        chk("mode", 8'h07, {5'h0, line_mode_o, half_duplex_o,
            reverse_channel_active_o});
        rev_break_req_i = 1'b1;
        cyc(1);
        chk("rev_break", 8'h00, 8'(sec_tx_data_o));
        rev_break_req_i = 1'b0;
        for (int i = 0; i < 2; i++) begin
            r = 8'($urandom_range(32'h20, 32'h7e));
            qtx.push_back(r);
            send(r);
            turnaround_char_select_i = i[0];
            qtx.push_back(`TPE_CHAR_CR);
            qtx.push_back(i ? `TPE_CHAR_EOT : `TPE_CHAR_ETX);
            send(`TPE_CHAR_CR);
        end
        tx_valid_i = 1'b0;
        cyc(10);
        for (int i = 0; i < 4; i++) begin
            parity_enable_i = i[1];
            // Range keeps BEL and NAK out so only parity can light
            r = 8'($urandom_range(32'h20, 32'hff));
            rx(r, i[0], (i == 3) ? `TPE_CHAR_NOT : r);
        end
        cyc(2);
        chk("lamps", 8'h01, 8'(error_lamps_o));
        chk("alarm", 8'h01, 8'(alarm_o));
        key();
        chk("lamps", 8'h00, 8'(error_lamps_o));
        cyc(20);
        for (int i = 0; i < 2; i++) begin
            next_column_i = 8'd132 + 8'(i);
            move_attempt_i = 1'b1;
            cyc(1);
            move_attempt_i = 1'b0;
            chk("cr_lf", i ? 8'h03 : 8'h00,
                {6'h0, local_cr_o, local_lf_o});
        end
        cyc(2);
        chk("alarm", 8'h00, 8'(alarm_o));
        for (int i = 0; i < 6; i++) begin
            cond = 6'(1 << i);
            print_attempt_i = 1'b1;
            cyc(1);
            print_attempt_i = 1'b0;
            key();
            chk("lamps", 8'(1 << bits[i]),
                8'(error_lamps_o));
            cond = '0;
            key();
            chk("lamps", 8'h00, 8'(error_lamps_o));
        end
        // Second power-up with the self-test switch on
        test_switch_i = 1'b1;
        printer_test_select_i = 1'b1;
        reset_i = 1'b1;
        cyc(2);
        reset_i = 1'b0;
        cyc(2);
        chk("state", 8'(ST_ROM), 8'(test_state_o));
        chk("pattern", 8'h01, 8'(pattern_b_o));
        for (int i = 0; i < 4; i++) begin
            r = 8'($urandom);
            kbd_key_code_i = r;
            check_fail_i = (i == 0);
            kbd_key_valid_i = (i == 2);
            check_done_i = (i != 2);
            cyc(1);
            if (i < 2)
                chk("kind", i ? 8'(PK_OK) : 8'(PK_BAD),
                    8'(test_print_kind_o));
            if (i == 2)
                chk("code", r, test_print_code_o);
        end
        check_done_i = 1'b0;
        kbd_key_valid_i = 1'b0;
        cyc(1);
        chk("code", `TPE_KBD_CHECK_A, test_print_code_o);
        cyc(1);
        chk("code", `TPE_KBD_CHECK_B, test_print_code_o);
        check_done_i = 1'b1;
        cyc(1);
        check_done_i = 1'b0;
        chk("state", 8'(ST_HALT), 8'(test_state_o));
        chk("lamps", 8'h7f, 8'(error_lamps_o));
        finish_test();
    end
    // Whole run needs a few microseconds
    initial begin
        #50us;
        num_errors++;
        finish_test();
    end
endmodule
`default_nettype wire

// File: verification/tpe_link_model.sv
// Far end of the serial link: byte sink with random stalls
`default_nettype none
module tpe_link_model (
    input  wire logic clk_sys_i,
    input  wire logic link_tx_valid_i,
    output logic      link_tx_ready_o,
    output logic      sec_rx_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Secondary line idles at mark, no break from here
    initial begin
        link_tx_ready_o = 1'b0;
        sec_rx_data_o = 1'b1;
    end
    // Stalls now and then so the sender must hold its byte
    always @(posedge clk_sys_i) begin
        link_tx_ready_o <= ($urandom % 4) != 0;
    end
endmodule
`default_nettype wire
